/* logic/pcgp_top.sv */
// pad configuration and gpio port with apb register access
`timescale 1ns/1ps
`include "pcgp_defs.svh"
module pcgp_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire pcgp_pkg::pcgp_apb_req_s apb_req,
  output pcgp_pkg::pcgp_apb_rsp_s apb_rsp,
  input wire logic [11:0] pad_in,
  input wire logic [11:0] periph_out,
  input wire logic [11:0] periph_oe,
  output pcgp_pkg::pcgp_pad_drv_s pad_drv,
  output logic [11:0] pad_hyst,
  output logic [11:0] pad_inmode,
  output logic [11:0] pad_lpf,
  output logic [1:0] bus_filter_en,
  output logic [3:0] sink_mode,
  output logic [11:0] sink_level_low,
  output logic [11:0] sink_level_high,
  output logic [17:0] analog_pin_config
);
  import pcgp_pkg::*;

  // ----------------------------------------
  // input synchroniser
  // ----------------------------------------
  logic [11:0] pin_meta_ff;
  logic [11:0] pin_sync_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_ff <= 12'h000;
      pin_sync_ff <= 12'h000;
    end
    else
    begin
      pin_meta_ff <= pad_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic [`PCGP_CFG_W-1:0] pad_config_block_ff [`PCGP_NPADS];
  logic [11:0] out_ff;
  logic [11:0] mask_ff;
  logic [11:0] port_direction_register_ff;
  logic [31:0] rdata_ff;
  logic ready_ff;
  logic err_ff;

  wire setup = apb_req.psel && !apb_req.penable;
  wire acc = apb_req.psel && apb_req.penable;
  wire wr = acc && apb_req.pwrite;
  wire [11:0] a = apb_req.paddr;
  wire [11:0] wd = apb_req.pwdata[11:0];
  wire is_pad = (a[11:8] == 4'h0) && (a[1:0] == 2'b00) && (a[7:2] < 6'd12);
  wire [3:0] pidx = a[5:2];
  wire is_gpio = (a == `PCGP_OUT) || (a == `PCGP_MASK) || (a == `PCGP_MOUT)
    || (a == `PCGP_SET) || (a == `PCGP_CLR) || (a == `PCGP_DIR)
    || (a == `PCGP_DIRSET) || (a == `PCGP_DIRCLR) || (a == `PCGP_DIRTGL)
    || (a == `PCGP_IN);

  // port write forms
  wire [11:0] out_full = (wr && a == `PCGP_OUT) ? wd : out_ff; // RULE_13
  wire [11:0] out_mask = (wr && a == `PCGP_MOUT) ?
    ((out_full & ~mask_ff) | (wd & mask_ff)) : out_full; // RULE_20
  wire [11:0] out_set = (wr && a == `PCGP_SET) ? (out_mask | wd) : out_mask; // RULE_12 RULE_19
  wire [11:0] nxt_out = (wr && a == `PCGP_CLR) ? (out_set & ~wd) : out_set; // RULE_19
  wire [11:0] dir_full = (wr && a == `PCGP_DIR) ? wd : port_direction_register_ff;
  wire [11:0] dir_s = (wr && a == `PCGP_DIRSET) ? (dir_full | wd) : dir_full; // RULE_17
  wire [11:0] dir_c = (wr && a == `PCGP_DIRCLR) ? (dir_s & ~wd) : dir_s; // RULE_17
  wire [11:0] nxt_dir = (wr && a == `PCGP_DIRTGL) ? (dir_c ^ wd) : dir_c; // RULE_17

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (is_pad)
      rd_mux = {16'h0000, pad_config_block_ff[pidx]};
    else if (a == `PCGP_OUT || a == `PCGP_MOUT)
      rd_mux = {20'h00000, out_ff};
    else if (a == `PCGP_MASK)
      rd_mux = {20'h00000, mask_ff};
    else if (a == `PCGP_DIR)
      rd_mux = {20'h00000, port_direction_register_ff};
    else if (a == `PCGP_IN)
      rd_mux = {20'h00000, pin_sync_ff};
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_ff <= 12'h000;
      mask_ff <= 12'hfff;
      port_direction_register_ff <= 12'h000; // RULE_16
      ready_ff <= 1'b0;
      err_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      out_ff <= nxt_out;
      port_direction_register_ff <= nxt_dir;
      if (wr && a == `PCGP_MASK)
        mask_ff <= wd;
      ready_ff <= setup; // RULE_14
      err_ff <= setup && !(apb_req.paddr[11:8] == 4'h0 ? is_pad : is_gpio);
      rdata_ff <= setup && !apb_req.pwrite ? rd_mux : 32'h0000_0000;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `PCGP_NPADS; g++)
    begin : g_pad
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          // bus and debug pads reset to their peripheral function
          pad_config_block_ff[g] <= (g == 4 || g == 5 || g == 10 || g == 11) ?
            `PCGP_CFG_OD_RST : `PCGP_CFG_RST; // RULE_05 RULE_16
        else if (wr && is_pad && pidx == 4'(g))
          pad_config_block_ff[g] <= apb_req.pwdata[`PCGP_CFG_W-1:0]; // RULE_18
      end
    end
  endgenerate

  // ready comes from a flop: high in the access phase, one cycle after setup
  assign apb_rsp.pready = ready_ff; // RULE_14
  assign apb_rsp.prdata = rdata_ff;
  assign apb_rsp.pslverr = err_ff;

  // ----------------------------------------
  // pad drive
  // ----------------------------------------
  logic [11:0] nxt_o, nxt_oe, nxt_pu, nxt_pd, nxt_hy, nxt_im, nxt_lp;
  logic [11:0] nxt_slo, nxt_shi;
  logic [3:0] nxt_sink;
  logic [1:0] nxt_bf;
  logic [17:0] nxt_ana;
  logic [2:0] fn;
  logic [1:0] pl;
  logic [2:0] adc_own, dac_own, i2d_own;
  logic [2:0] nb;
  always_comb
  begin
    nxt_o = 12'h000; nxt_oe = 12'h000; nxt_pu = 12'h000; nxt_pd = 12'h000;
    nxt_hy = 12'h000; nxt_im = 12'h000; nxt_lp = 12'h000;
    nxt_slo = 12'h000; nxt_shi = 12'h000; nxt_sink = 4'h0; nxt_bf = 2'b00;
    nxt_ana = 18'h00000; adc_own = 3'h7; dac_own = 3'h7; i2d_own = 3'h7;
    fn = 3'h0; pl = 2'h0; nb = 3'h0;
    for (int i = 0; i < `PCGP_NPADS; i++)
    begin
      fn = pad_config_block_ff[i][`PCGP_F_PIN_FUNCTION_SELECT_LO +: 3];
      pl = pad_config_block_ff[i][`PCGP_F_PULL_LO +: 2];
      // fixed pad per port bit
      if (fn == `PCGP_PIN_FUNCTION_SELECT_GPIO) // RULE_01 RULE_15
      begin
        nxt_o[i] = out_ff[i];
        nxt_oe[i] = port_direction_register_ff[i]; // RULE_02
      end
      else
      begin
        nxt_o[i] = periph_out[i];
        nxt_oe[i] = periph_oe[i]; // RULE_03
      end
      case (pl) // RULE_04
        `PCGP_PULL_UP: nxt_pu[i] = 1'b1;
        `PCGP_PULL_DOWN: nxt_pd[i] = 1'b1;
        `PCGP_PULL_RPT:
        begin
          nxt_pu[i] = pin_sync_ff[i]; // RULE_06 RULE_07
          nxt_pd[i] = !pin_sync_ff[i]; // RULE_06
        end
        default: ;
      endcase
      nxt_hy[i] = pad_config_block_ff[i][`PCGP_F_HYS]; // RULE_18
      nxt_im[i] = pad_config_block_ff[i][`PCGP_F_INMODE];
      nxt_lp[i] = pad_config_block_ff[i][`PCGP_F_LPF];
      nxt_slo[i] = |pad_config_block_ff[i][`PCGP_F_SLO_LO +: 3];
      nxt_shi[i] = |pad_config_block_ff[i][`PCGP_F_SHI_LO +: 3];
      if (i < `PCGP_NANA)
      begin
        // first pad claiming a converter wins it
        if (fn == `PCGP_PIN_FUNCTION_SELECT_ADC && adc_own == 3'h7)
          adc_own = 3'(i); // RULE_10 RULE_11
        if (fn == `PCGP_PIN_FUNCTION_SELECT_DAC && dac_own == 3'h7)
          dac_own = 3'(i); // RULE_11
        if (fn == `PCGP_PIN_FUNCTION_SELECT_I2D && i2d_own == 3'h7)
          i2d_own = 3'(i); // RULE_11
      end
    end
    for (int i = 0; i < `PCGP_NANA; i++)
      nxt_ana[3*i +: 3] = {i2d_own == 3'(i), dac_own == 3'(i), adc_own == 3'(i)}; // RULE_10
    // high-source pads: 3, 7, 10, 11
    for (int k = 0; k < 4; k++)
    begin
      nb = (k == 0) ? 3'd3 : (k == 1) ? 3'd7 : (k == 2) ? 3'd2 : 3'd3;
      nxt_sink[k] = pad_config_block_ff[k < 2 ? 4'(nb) : 4'(8 + nb)][`PCGP_F_SINK]; // RULE_09
    end
    // bus pads 4 and 5: filtered when set to a peripheral function unless plain open-drain chosen
    for (int k = 0; k < 2; k++)
    begin
      nxt_bf[k] = (pad_config_block_ff[4 + k][`PCGP_F_PIN_FUNCTION_SELECT_LO +: 3] != `PCGP_PIN_FUNCTION_SELECT_GPIO)
        && !pad_config_block_ff[4 + k][`PCGP_F_I2CPLAIN]; // RULE_08
      if (pad_config_block_ff[4 + k][`PCGP_F_PIN_FUNCTION_SELECT_LO +: 3] != `PCGP_PIN_FUNCTION_SELECT_GPIO)
      begin
        nxt_oe[4 + k] = periph_oe[4 + k] && !periph_out[4 + k]; // RULE_08
        nxt_o[4 + k] = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_drv <= '0;
      pad_hyst <= 12'h000;
      pad_inmode <= 12'h000;
      pad_lpf <= 12'h000;
      bus_filter_en <= 2'b00;
      sink_mode <= 4'h0;
      sink_level_low <= 12'h000;
      sink_level_high <= 12'h000;
      analog_pin_config <= 18'h00000;
    end
    else
    begin
      pad_drv <= '{out: nxt_o, oe: nxt_oe, pull_up: nxt_pu, pull_down: nxt_pd};
      pad_hyst <= nxt_hy;
      pad_inmode <= nxt_im;
      pad_lpf <= nxt_lp;
      bus_filter_en <= nxt_bf;
      sink_mode <= nxt_sink;
      sink_level_low <= nxt_slo;
      sink_level_high <= nxt_shi;
      analog_pin_config <= nxt_ana;
    end
  end
endmodule : pcgp_top

/* shared/pcgp_defs.svh */
// constants of the pad configuration and gpio port block
// Function
// RULE_01: function field zero makes the pad a gpio pin, otherwise peripheral.
// RULE_02: for gpio pads the direction bit picks input or output.
// RULE_03: peripheral pads take direction from the peripheral, ignoring direction bits.
// RULE_04: pull field selects pull-up, pull-down, none or repeater.
// RULE_05: pull field resets to no pull resistor.
// RULE_06: repeater enables pull matching the pad's current level.
// RULE_07: repeater retention need not survive deepest power-down.
// RULE_08: serial-bus pads choose filtered bus mode or plain open-drain.
// RULE_09: high-source pads offer digital mode or two-level current sink mode.
// RULE_10: function field picks analog bus connections of analog pins.
// RULE_11: each converter connects to only one analog pin at a time.
// RULE_12: one write may set or clear any number of output bits.
// RULE_13: masked, set, clear and full-port writes are supported.
// RULE_14: every register access completes in a single cycle.
// RULE_15: each port bit is fixed to one pad.
// RULE_16: reset leaves pads gpio inputs without pulls except bus and debug pads.
// RULE_17: direction bits can be set, cleared and toggled per pin.
// RULE_18: pad config also holds input mode, hysteresis, filter and keeper.
// RULE_19: set and clear writes change only bits written as one.
// RULE_20: masked writes change only bits enabled by the mask.
`ifndef PCGP_DEFS_SVH
`define PCGP_DEFS_SVH
`define PCGP_NPADS 12
`define PCGP_NANA 6
// register byte offsets
`define PCGP_PAD_BASE 12'h000
`define PCGP_OUT 12'h100
`define PCGP_MASK 12'h104
`define PCGP_MOUT 12'h108
`define PCGP_SET 12'h10c
`define PCGP_CLR 12'h110
`define PCGP_DIR 12'h114
`define PCGP_DIRSET 12'h118
`define PCGP_DIRCLR 12'h11c
`define PCGP_DIRTGL 12'h120
`define PCGP_IN 12'h124
// pad config field positions
`define PCGP_F_PIN_FUNCTION_SELECT_LO 0
`define PCGP_F_PULL_LO 3
`define PCGP_F_HYS 5
`define PCGP_F_INMODE 6
`define PCGP_F_LPF 7
`define PCGP_F_I2CPLAIN 8
`define PCGP_F_SINK 9
`define PCGP_F_SLO_LO 10
`define PCGP_F_SHI_LO 13
`define PCGP_CFG_W 16
`define PCGP_CFG_RST 16'h0000
`define PCGP_CFG_OD_RST 16'h0001
`define PCGP_PULL_NONE 2'h0
`define PCGP_PULL_DOWN 2'h1
`define PCGP_PULL_UP 2'h2
`define PCGP_PULL_RPT 2'h3
`define PCGP_PIN_FUNCTION_SELECT_GPIO 3'h0
`define PCGP_PIN_FUNCTION_SELECT_ADC 3'h1
`define PCGP_PIN_FUNCTION_SELECT_DAC 3'h2
`define PCGP_PIN_FUNCTION_SELECT_I2D 3'h3
`endif

/* shared/pcgp_pkg.sv */
// types of the pad configuration and gpio port block
package pcgp_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } pcgp_apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pcgp_apb_rsp_s;
  typedef struct packed {
    logic [11:0] out;
    logic [11:0] oe;
    logic [11:0] pull_up;
    logic [11:0] pull_down;
  } pcgp_pad_drv_s;
endpackage : pcgp_pkg

/* verif/pcgp_top_assertions.sv */
// assertions on the pad configuration and gpio port
`timescale 1ns/1ps
module pcgp_top_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire pcgp_pkg::pcgp_apb_req_s apb_req,
  input wire pcgp_pkg::pcgp_apb_rsp_s apb_rsp,
  input wire pcgp_pkg::pcgp_pad_drv_s pad_drv,
  input wire logic [1:0] bus_filter_en,
  input wire logic [17:0] analog_pin_config
);
  import pcgp_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire [5:0] adc_sel = {analog_pin_config[15], analog_pin_config[12], analog_pin_config[9],
    analog_pin_config[6], analog_pin_config[3], analog_pin_config[0]};
  wire [5:0] dac_sel = {analog_pin_config[16], analog_pin_config[13],
    analog_pin_config[10], analog_pin_config[7], analog_pin_config[4], analog_pin_config[1]};
  wire [5:0] i2d_sel = {analog_pin_config[17], analog_pin_config[14], analog_pin_config[11],
    analog_pin_config[8], analog_pin_config[5], analog_pin_config[2]};
  wire setup_ph = apb_req.psel && !apb_req.penable;
  rdy_high_a: assert property (setup_ph |=> apb_rsp.pready)
    else $error("pready low in access phase");
  err_unmapped_a: assert property (setup_ph && apb_req.paddr == 12'h200 |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
    else $error("unmapped access not refused");
  err_mapped_a: assert property (setup_ph && apb_req.paddr == 12'h100 |=> !apb_rsp.pslverr)
    else $error("mapped access refused");
  adc_single_a: assert property ($onehot0(adc_sel))
    else $error("adc on two pins");
  dac_single_a: assert property ($onehot0(dac_sel))
    else $error("dac on two pins");
  i2d_single_a: assert property ($onehot0(i2d_sel))
    else $error("i2d on two pins");
  pull_excl_a: assert property (!(|(pad_drv.pull_up & pad_drv.pull_down)))
    else $error("both pulls on");
  reset_idle_a: assert property ($rose(presetn) |-> (pad_drv.oe | pad_drv.pull_up | pad_drv.pull_down) == 12'h0)
    else $error("pad not idle input after reset");
  filter_rst_a: assert property ($rose(presetn) |=> bus_filter_en == 2'h3)
    else $error("bus pads not filtered after reset");
endmodule : pcgp_top_assertions
bind pcgp_top pcgp_top_assertions u_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .pad_drv(pad_drv), .bus_filter_en(bus_filter_en),
  .analog_pin_config(analog_pin_config));

/* verif/pcgp_pins_model.sv */
// pin and load model of the pad port
`timescale 1ns/1ps
module pcgp_pins_model (
  input wire logic pclk,
  input wire pcgp_pkg::pcgp_pad_drv_s pad_drv,
  input wire logic [11:0] ext_en,
  input wire logic [11:0] ext_val,
  output logic [11:0] pad_in
);
  import pcgp_pkg::*;
  logic [11:0] last_ff = 12'h0;
  always_ff @(posedge pclk)
  begin
    last_ff <= pad_in;
  end
  // driver, then external load, then pulls; a floating pin wanders
  always_comb
  begin
    for (int i = 0; i < 12; i++)
    begin
      if (pad_drv.oe[i]) pad_in[i] = pad_drv.out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_drv.pull_up[i]) pad_in[i] = 1'b1;
      else if (pad_drv.pull_down[i]) pad_in[i] = 1'b0;
      else pad_in[i] = ~last_ff[i];
    end
  end
endmodule : pcgp_pins_model

/* verif/pcgp_top_bench.sv */
// self-checking bench of the pad configuration and gpio port
`timescale 1ns/1ps
`define CHK(n, e, v) begin num_checks++; if ((v) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", n, e, v); end end
module pcgp_top_bench;
  import pcgp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  pcgp_apb_req_s req = '0;
  pcgp_apb_rsp_s rsp;
  pcgp_pad_drv_s drv;
  logic [11:0] pout = 12'h0, poe = 12'h0, ext_en = 12'h0, ext_val = 12'h0;
  logic [11:0] pad_in, hyst, inmode, lpf, slo, shi;
  logic [1:0] bfe;
  logic [3:0] smode;
  logic [17:0] ana;
  logic [31:0] rd;
  logic er;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  always #10 pclk = ~pclk;
  pcgp_top DUT (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .pad_in(pad_in),
    .periph_out(pout), .periph_oe(poe), .pad_drv(drv), .pad_hyst(hyst), .pad_inmode(inmode),
    .pad_lpf(lpf), .bus_filter_en(bfe), .sink_mode(smode), .sink_level_low(slo),
    .sink_level_high(shi), .analog_pin_config(ana));
  pcgp_pins_model u_pins (.pclk(pclk), .pad_drv(drv), .ext_en(ext_en), .ext_val(ext_val),
    .pad_in(pad_in));
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : xfer
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string n);
    xfer(1'b0, a, 32'h0);
    `CHK(n, e, rd)
  endtask : rchk
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  task automatic t_reset;
    rchk(12'h000, 32'h0, "cfg0");
    rchk(12'h010, 32'h1, "cfg4");
    rchk(12'h114, 32'h0, "dir");
    `CHK("filter", 2'h3, bfe)
    $display("done reset");
  endtask : t_reset
  task automatic t_port;
    xfer(1'b1, 12'h100, 32'h0a5);
    xfer(1'b1, 12'h10c, 32'h300);
    xfer(1'b1, 12'h110, 32'h005);
    rchk(12'h100, 32'h3a0, "set clr");
    xfer(1'b1, 12'h104, 32'h0f0);
    xfer(1'b1, 12'h108, 32'hfff);
    rchk(12'h100, 32'h3f0, "masked");
    xfer(1'b1, 12'h118, 32'h00f);
    xfer(1'b1, 12'h11c, 32'h003);
    xfer(1'b1, 12'h120, 32'h0ff);
    rchk(12'h114, 32'h0f3, "dir ops");
    repeat (2) @(posedge pclk);
    `CHK("oe", 12'h0c3, drv.oe)
    `CHK("out", 12'h0c0, drv.out & drv.oe)
    poe <= 12'hfff;
    pout <= 12'h400;
    repeat (3) @(posedge pclk);
    `CHK("oe periph", 12'hcf3, drv.oe)
    `CHK("out periph", 12'h4c0, drv.out & drv.oe)
    poe <= 12'h0;
    pout <= 12'h0;
    $display("done port");
  endtask : t_port
  task automatic t_pull;
    xfer(1'b1, 12'h020, 32'h10);
    repeat (2) @(posedge pclk);
    `CHK("up", 2'b10, {drv.pull_up[8], drv.pull_down[8]})
    xfer(1'b1, 12'h020, 32'h08);
    repeat (2) @(posedge pclk);
    `CHK("down", 2'b01, {drv.pull_up[8], drv.pull_down[8]})
    ext_en <= 12'h100;
    ext_val <= 12'h100;
    xfer(1'b1, 12'h020, 32'hf8);
    repeat (6) @(posedge pclk);
    `CHK("rpt hi", 2'b10, {drv.pull_up[8], drv.pull_down[8]})
    `CHK("pad opts", 3'b111, {hyst[8], inmode[8], lpf[8]})
    ext_val <= 12'h0;
    repeat (6) @(posedge pclk);
    ext_en <= 12'h0;
    repeat (6) @(posedge pclk);
    `CHK("rpt hold", 2'b01, {drv.pull_up[8], drv.pull_down[8]})
    xfer(1'b0, 12'h124, 32'h0);
    `CHK("in8", 1'b0, rd[8])
    $display("done pull");
  endtask : t_pull
  task automatic t_misc;
    xfer(1'b1, 12'h00c, 32'h2600);
    repeat (2) @(posedge pclk);
    `CHK("sink", 3'b111, {smode[0], slo[3], shi[3]})
    xfer(1'b1, 12'h000, 32'h1);
    xfer(1'b1, 12'h004, 32'h1);
    xfer(1'b1, 12'h008, 32'h2);
    xfer(1'b1, 12'h00c, 32'h3);
    repeat (2) @(posedge pclk);
    `CHK("analog", 18'h00881, ana)
    xfer(1'b1, 12'h200, 32'h5);
    `CHK("err", 1'b1, er)
    $display("done misc");
  endtask : t_misc
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      summarize();
    end
  end
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_port();
    t_pull();
    t_misc();
    summarize();
  end
endmodule : pcgp_top_bench
